// [logic/dac_output_noise_gate.v]
// Function
// R1 - Playback is muted only after the peak stays below the engage level for a full hold length.
// R2 - The hold code selects 256, 512, 1024 or 2048 samples for codes 0 to 3.
// R3 - Mute slope bit 3 picks 0.88 ms per dB when clear and 14.08 ms per dB when set.
// R4 - Unmute slope bit 2 picks 0.22 ms per dB when clear and 0.0138 ms per dB when set.
// R5 - The gate opens above the release level, coded -102 dB (000) to -60 dB (111) in 6 dB steps.
// R6 - The engage level uses the same scale and arms the gate when the signal falls below it.
// R7 - Release code 011 means -84 dB and code 100 means -78 dB, on the uniform 6 dB grid.
// R8 - The gate acts only while control bit 7 is set; otherwise data passes ungated.
// R9 - The hold counter advances per sample and restarts on any sample above the engage level.
`timescale 1ns/1ps
`default_nettype none
`include "noise_gate_regs.vh"

module dac_output_noise_gate #(
  parameter DATA_W = 24,
  parameter MUTE_DB = 96,
  parameter DOWN_NORMAL_CYC = `NG_DOWN_NORMAL_NS / `NG_CLK_PERIOD_NS,
  parameter DOWN_SLOW_CYC = `NG_DOWN_SLOW_NS / `NG_CLK_PERIOD_NS,
  parameter UP_NORMAL_CYC = `NG_UP_NORMAL_NS / `NG_CLK_PERIOD_NS,
  parameter UP_FAST_CYC = `NG_UP_FAST_NS / `NG_CLK_PERIOD_NS
) (
  input wire CLOCK_IN,
  input wire RESETN_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output wire [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire SAMPLE_VALID_IN,
  input wire [DATA_W-1:0] LEFT_IN,
  input wire [DATA_W-1:0] RIGHT_IN,
  output wire SAMPLE_VALID_OUT,
  output wire [DATA_W-1:0] LEFT_OUT,
  output wire [DATA_W-1:0] RIGHT_OUT,
  output wire GATE_MUTED_OUT
);

  localparam CNT_W = 19;
  localparam ATT_W = 7;
  localparam [ATT_W-1:0] ATT_MUTE = MUTE_DB[ATT_W-1:0];
  localparam [CNT_W-1:0] DOWN_NORMAL = DOWN_NORMAL_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] DOWN_SLOW = DOWN_SLOW_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] UP_NORMAL = UP_NORMAL_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] UP_FAST = UP_FAST_CYC[CNT_W-1:0];
  localparam [1:0] ST_OPEN = 2'h0;
  localparam [1:0] ST_CLOSING = 2'h1;
  localparam [1:0] ST_MUTED = 2'h2;
  localparam [1:0] ST_OPENING = 2'h3;
  localparam [7:0] CTRL_RST = `NG_CONTROL_RST, RH_RST = `NG_RAMP_HOLD_RST;
  localparam [7:0] REL_RST = `NG_RELEASE_RST, ENG_RST = `NG_ENGAGE_RST;
  // Magnitude of a signed sample; the most negative code saturates
  function [DATA_W-1:0] magnitude;
    input [DATA_W-1:0] x;
    begin
      if (!x[DATA_W-1])
        magnitude = x;
      else if (x[DATA_W-2:0] == {(DATA_W-1){1'b0}})
        magnitude = {1'b0, {(DATA_W-1){1'b1}}};
      else
        magnitude = ~x + {{(DATA_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Level code to linear magnitude, one bit (about 6 dB) per code step
  function [DATA_W-1:0] level_of;
    input [2:0] code;
    begin
      level_of = {{(DATA_W-1){1'b0}}, 1'b1} << (`NG_LEVEL_BASE_SHIFT + code); // [R5] [R6] [R7]
    end
  endfunction

  // Apply attenuation: whole 6 dB steps by shift, the remainder by a Q8 factor
  function [DATA_W-1:0] attenuate;
    input [DATA_W-1:0] x;
    input [ATT_W-1:0] att;
    reg [ATT_W-1:0] whole;
    reg [ATT_W-1:0] part;
    reg [8:0] fac;
    reg signed [DATA_W+9:0] prod;
    begin
      whole = att / 7'h06;
      part = att - whole * 7'h06;
      case (part)
        7'h00: fac = 9'h100;
        7'h01: fac = 9'h0e4;
        7'h02: fac = 9'h0cb;
        7'h03: fac = 9'h0b5;
        7'h04: fac = 9'h0a2;
        default: fac = 9'h090;
      endcase
      prod = $signed(x) * $signed({1'b0, fac});
      prod = prod >>> 8;
      prod = prod >>> whole;
      if (att >= ATT_MUTE)
        attenuate = {DATA_W{1'b0}};
      else
        attenuate = prod[DATA_W-1:0];
    end
  endfunction

  // Register state; only the documented fields are stored, the rest read zero
  reg gate_enable_q;
  reg mute_slope_select_q;
  reg unmute_slope_select_q;
  reg [1:0] quiet_hold_length_q;
  reg [2:0] release_level_code_q;
  reg [2:0] engage_level_code_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;

  // Gate state
  reg [1:0] state_q;
  reg [11:0] hold_cnt_q;
  reg valid_q;
  reg [DATA_W-1:0] left_q;
  reg [DATA_W-1:0] right_q;
  reg muted_q;
  wire [ATT_W-1:0] att;
  wire [DATA_W-1:0] mag_l = magnitude(LEFT_IN);
  wire [DATA_W-1:0] mag_r = magnitude(RIGHT_IN);
  wire [DATA_W-1:0] peak = (mag_l > mag_r) ? mag_l : mag_r;
  wire quiet = peak < level_of(engage_level_code_q); // [R6]
  wire loud = peak > level_of(release_level_code_q); // [R5]
  wire [11:0] hold_len = `NG_HOLD_BASE << quiet_hold_length_q; // [R2]

  // APB decode: byte address is four times the register index
  wire [9:0] word = PADDR_IN[11:2];
  wire hit_ctrl = (word == {2'b00, `NG_IDX_CONTROL});
  wire hit_ramp = (word == {2'b00, `NG_IDX_RAMP_HOLD});
  wire hit_rel = (word == {2'b00, `NG_IDX_RELEASE});
  wire hit_eng = (word == {2'b00, `NG_IDX_ENGAGE});
  wire hit_stat = (word == {2'b00, `NG_IDX_STATUS});
  wire mapped = hit_ctrl | hit_ramp | hit_rel | hit_eng | hit_stat;
  wire access = PSEL_IN && PENABLE_IN;
  wire wr_now = access && pready_q && PWRITE_IN;
  reg [31:0] rd_data;

  // Read multiplexer; status shows gate state and present attenuation
  always @* begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl)
      rd_data[`NG_ENABLE_BIT] = gate_enable_q;
    if (hit_ramp) begin
      rd_data[`NG_MUTE_SLOPE_BIT] = mute_slope_select_q;
      rd_data[`NG_UNMUTE_SLOPE_BIT] = unmute_slope_select_q;
      rd_data[`NG_HOLD_MSB:`NG_HOLD_LSB] = quiet_hold_length_q;
    end
    if (hit_rel)
      rd_data[`NG_LEVEL_MSB:`NG_LEVEL_LSB] = release_level_code_q;
    if (hit_eng)
      rd_data[`NG_LEVEL_MSB:`NG_LEVEL_LSB] = engage_level_code_q;
    if (hit_stat)
      rd_data[9:0] = {1'b0, att, state_q};
  end

  // One wait state: pready rises after the first access cycle, so read data is settled
  always @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= PWRITE_IN ? 32'h0000_0000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // Writes take effect at the completing edge only; status is read-only
  always @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      gate_enable_q <= CTRL_RST[`NG_ENABLE_BIT];
      mute_slope_select_q <= RH_RST[`NG_MUTE_SLOPE_BIT];
      unmute_slope_select_q <= RH_RST[`NG_UNMUTE_SLOPE_BIT];
      quiet_hold_length_q <= RH_RST[`NG_HOLD_MSB:`NG_HOLD_LSB];
      release_level_code_q <= REL_RST[`NG_LEVEL_MSB:`NG_LEVEL_LSB];
      engage_level_code_q <= ENG_RST[`NG_LEVEL_MSB:`NG_LEVEL_LSB];
    end else if (wr_now) begin
      if (hit_ctrl)
        gate_enable_q <= PWDATA_IN[`NG_ENABLE_BIT];
      if (hit_ramp) begin
        mute_slope_select_q <= PWDATA_IN[`NG_MUTE_SLOPE_BIT];
        unmute_slope_select_q <= PWDATA_IN[`NG_UNMUTE_SLOPE_BIT];
        quiet_hold_length_q <= PWDATA_IN[`NG_HOLD_MSB:`NG_HOLD_LSB];
      end
      if (hit_rel)
        release_level_code_q <= PWDATA_IN[`NG_LEVEL_MSB:`NG_LEVEL_LSB];
      if (hit_eng)
        engage_level_code_q <= PWDATA_IN[`NG_LEVEL_MSB:`NG_LEVEL_LSB];
    end
  end

  // Ramp drive and slope choice
  wire ramp_down = (state_q == ST_CLOSING);
  wire ramp_up = (state_q == ST_OPENING);
  wire [CNT_W-1:0] step_cycles = ramp_down ?
    (mute_slope_select_q ? DOWN_SLOW : DOWN_NORMAL) : // [R3]
    (unmute_slope_select_q ? UP_FAST : UP_NORMAL); // [R4]

  gain_ramp #(
    .ATT_W(ATT_W),
    .MUTE_DB(MUTE_DB),
    .CNT_W(CNT_W)
  ) u_ramp (
    .clk_in(CLOCK_IN),
    .rstn_in(RESETN_IN),
    .clear_in(!gate_enable_q), // [R8]
    .down_in(ramp_down),
    .up_in(ramp_up),
    .step_cycles_in(step_cycles),
    .att_out(att)
  );

  // Gate sequencer; a loud sample during the fall turns straight to the rise
  always @(posedge CLOCK_IN) begin
    if (!RESETN_IN || !gate_enable_q) begin
      state_q <= ST_OPEN; // [R8]
      hold_cnt_q <= 12'h000;
    end else begin
      case (state_q)
        ST_OPEN: begin
          if (SAMPLE_VALID_IN) begin
            if (!quiet) begin
              hold_cnt_q <= 12'h000; // [R9]
            end else if (hold_cnt_q == hold_len - 12'h001) begin
              hold_cnt_q <= 12'h000;
              state_q <= ST_CLOSING; // [R1]
            end else begin
              hold_cnt_q <= hold_cnt_q + 12'h001; // [R9]
            end
          end
        end
        ST_CLOSING: begin
          if (SAMPLE_VALID_IN && loud)
            state_q <= ST_OPENING; // [R5]
          else if (att == ATT_MUTE)
            state_q <= ST_MUTED;
        end
        ST_MUTED: begin
          if (SAMPLE_VALID_IN && loud)
            state_q <= ST_OPENING; // [R5]
        end
        ST_OPENING: begin
          if (att == {ATT_W{1'b0}})
            state_q <= ST_OPEN;
        end
        default: state_q <= ST_OPEN;
      endcase
    end
  end

  // Output samples registered one cycle behind their input strobe
  always @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      valid_q <= 1'b0;
      left_q <= {DATA_W{1'b0}};
      right_q <= {DATA_W{1'b0}};
      muted_q <= 1'b0;
    end else begin
      valid_q <= SAMPLE_VALID_IN;
      muted_q <= (state_q == ST_MUTED);
      if (SAMPLE_VALID_IN) begin
        left_q <= attenuate(LEFT_IN, att); // [R1]
        right_q <= attenuate(RIGHT_IN, att);
      end
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign SAMPLE_VALID_OUT = valid_q;
  assign LEFT_OUT = left_q;
  assign RIGHT_OUT = right_q;
  assign GATE_MUTED_OUT = muted_q;

endmodule // dac_output_noise_gate

`default_nettype wire

// [common/noise_gate_regs.vh]
`ifndef NOISE_GATE_REGS_VH
`define NOISE_GATE_REGS_VH

// Register indices; byte address is four times the index
`define NG_IDX_CONTROL 8'h9c
`define NG_IDX_RAMP_HOLD 8'h9d
`define NG_IDX_RELEASE 8'h9e
`define NG_IDX_ENGAGE 8'h9f
`define NG_IDX_STATUS 8'ha0

// Field positions
`define NG_ENABLE_BIT 7
`define NG_MUTE_SLOPE_BIT 3
`define NG_UNMUTE_SLOPE_BIT 2
`define NG_HOLD_MSB 1
`define NG_HOLD_LSB 0
`define NG_LEVEL_MSB 2
`define NG_LEVEL_LSB 0

// Reset values
`define NG_CONTROL_RST 8'h00
`define NG_RAMP_HOLD_RST 8'h00
`define NG_RELEASE_RST 8'h00
`define NG_ENGAGE_RST 8'h00

// Hold length at code 0, in samples
`define NG_HOLD_BASE 12'h100

// Level code 0 (-102 dB) as a power of two below a 24-bit full scale
`define NG_LEVEL_BASE_SHIFT 6

// Ramp times per dB in ns, and the clock period in ns
`define NG_CLK_PERIOD_NS 50
`define NG_DOWN_NORMAL_NS 880000
`define NG_DOWN_SLOW_NS 14080000
`define NG_UP_NORMAL_NS 220000
`define NG_UP_FAST_NS 13800

`endif

// [logic/gain_ramp.v]
`timescale 1ns/1ps
`default_nettype none

// Attenuation counter in 1 dB steps, one step per step_cycles_in clocks
module gain_ramp #(
  parameter ATT_W = 7,
  parameter MUTE_DB = 96,
  parameter CNT_W = 19
) (
  input wire clk_in,
  input wire rstn_in,
  input wire clear_in,
  input wire down_in,
  input wire up_in,
  input wire [CNT_W-1:0] step_cycles_in,
  output wire [ATT_W-1:0] att_out
);

  localparam [ATT_W-1:0] ATT_MAX = MUTE_DB[ATT_W-1:0];
  localparam [ATT_W-1:0] ATT_ONE = {{(ATT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] cnt_q;
  reg [ATT_W-1:0] att_q;
  wire step = (cnt_q >= step_cycles_in - CNT_ONE);

  // Timer restarts whenever no ramp runs, so each ramp except a rise turned straight from the fall begins on a full step
  always @(posedge clk_in) begin
    if (!rstn_in || clear_in) begin
      cnt_q <= {CNT_W{1'b0}};
      att_q <= {ATT_W{1'b0}};
    end else if (down_in || up_in) begin
      if (step) begin
        cnt_q <= {CNT_W{1'b0}};
        if (down_in && att_q < ATT_MAX)
          att_q <= att_q + ATT_ONE;
        else if (up_in && !down_in && att_q != {ATT_W{1'b0}})
          att_q <= att_q - ATT_ONE;
      end else begin
        cnt_q <= cnt_q + CNT_ONE;
      end
    end else begin
      cnt_q <= {CNT_W{1'b0}};
    end
  end

  assign att_out = att_q;

endmodule // gain_ramp

`default_nettype wire

// [testbench/dac_output_noise_gate_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module dac_output_noise_gate_checker #(parameter DATA_W = 24) (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic SAMPLE_VALID_OUT,
  input wire logic [DATA_W-1:0] LEFT_OUT,
  input wire logic [DATA_W-1:0] RIGHT_OUT,
  input wire logic GATE_MUTED_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Access phase still waiting for its single wait state
  sequence access_s;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  // Settled mute: high this cycle and the two before, so a ramp start cannot be mistaken for it
  sequence settled_mute_s;
    SAMPLE_VALID_OUT && GATE_MUTED_OUT && $past(GATE_MUTED_OUT) && $past(GATE_MUTED_OUT, 2);
  endsequence
  AST_READY_WAIT: assert property (access_s |=> PREADY_OUT) else $error("ready late");
  AST_READY_CAUSE: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
    else $error("ready without access");
  AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
  AST_RDATA_IDLE: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside answer");
  AST_ERR_WITH_READY: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("stray error");
  AST_VALID_DELAY: assert property (1'b1 |=> SAMPLE_VALID_OUT == $past(SAMPLE_VALID_IN))
    else $error("valid not one cycle late");
  AST_DATA_HELD: assert property (!$past(SAMPLE_VALID_IN) |->
    $stable(LEFT_OUT) && $stable(RIGHT_OUT)) else $error("data moved without strobe");
  AST_MUTED_ZERO: assert property (settled_mute_s |-> LEFT_OUT == '0 && RIGHT_OUT == '0)
    else $error("sound while muted");
endmodule // dac_output_noise_gate_checker
bind dac_output_noise_gate dac_output_noise_gate_checker #(.DATA_W(DATA_W)) u_checker (
  .CLOCK_IN, .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
  .SAMPLE_VALID_IN, .SAMPLE_VALID_OUT, .LEFT_OUT, .RIGHT_OUT, .GATE_MUTED_OUT);
`default_nettype wire

// [testbench/dac_sample_source.sv]
`timescale 1ns/1ps
`default_nettype none
// Upstream filter path: one stereo strobe every other clock
module dac_sample_source #(parameter DATA_W = 24) (
  input wire logic clk_in,
  output logic valid_out = 1'b0,
  output logic [DATA_W-1:0] left_out = '0,
  output logic [DATA_W-1:0] right_out = '0
);
  // Peak on the right with negative sign; left carries half of it
  task send(input int n, input logic [DATA_W-1:0] amp);
    repeat (n) begin
      @(posedge clk_in);
      valid_out <= 1'b1;
      left_out <= amp >> 1;
      right_out <= -amp;
      @(posedge clk_in);
      valid_out <= 1'b0;
      left_out <= ~left_out; // Not held, so a stale word cannot slip through
      right_out <= ~right_out;
    end
  endtask
endmodule // dac_sample_source
`default_nettype wire

// [testbench/dac_output_noise_gate_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "noise_gate_regs.vh"
module dac_output_noise_gate_bench;
  localparam logic [11:0] A_CTL = 12'(`NG_IDX_CONTROL) << 2;
  localparam logic [11:0] A_RH = 12'(`NG_IDX_RAMP_HOLD) << 2;
  localparam logic [11:0] A_REL = 12'(`NG_IDX_RELEASE) << 2;
  localparam logic [11:0] A_ENG = 12'(`NG_IDX_ENGAGE) << 2;
  localparam logic [11:0] A_ST = 12'(`NG_IDX_STATUS) << 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire sv;
  wire [23:0] l_in;
  wire [23:0] r_in;
  wire [23:0] l_out;
  wire [23:0] r_out;
  wire vout;
  wire muted;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  dac_sample_source u_dac_sample_source (.clk_in(clk), .valid_out(sv), .left_out(l_in),
    .right_out(r_in));
  // Short ramps: 12 dB to mute, 4/8 cycles per dB down, 3/2 up
  dac_output_noise_gate #(.MUTE_DB(12), .DOWN_NORMAL_CYC(4), .DOWN_SLOW_CYC(8),
    .UP_NORMAL_CYC(3), .UP_FAST_CYC(2)) u_dac_output_noise_gate (.CLOCK_IN(clk),
    .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SAMPLE_VALID_IN(sv), .LEFT_IN(l_in), .RIGHT_IN(r_in), .SAMPLE_VALID_OUT(vout),
    .LEFT_OUT(l_out), .RIGHT_OUT(r_out), .GATE_MUTED_OUT(muted));
  initial begin
    forever #25 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request held until ready is seen high at a rising edge; a hang is left to the timeout
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Gate off first so every setup starts from the open state
  task cfg(input logic en, input logic [3:0] rh, input logic [2:0] lvl);
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_RH, {28'h0, rh});
    apb(1'b1, A_REL, {29'h0, lvl});
    apb(1'b1, A_ENG, {29'h0, lvl});
    apb(1'b1, A_CTL, {24'h0, en, 7'h0});
  endtask
  task t_regs;
    logic [11:0] a [4];
    logic [7:0] m [4];
    a = '{A_CTL, A_RH, A_REL, A_ENG};
    m = '{8'h80, 8'h0f, 8'h07, 8'h07};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, a[i], 32'h0);
      check(rd, 32'h0);
      apb(1'b1, a[i], 32'hffffffff);
      apb(1'b0, a[i], 32'h0);
      check(rd, {24'h0, m[i]});
    end
    apb(1'b1, 12'h300, 32'h1);
    check(err, 1'b1);
    apb(1'b0, 12'h300, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
  endtask
  // One loud sample in place of the last but one quiet sample restarts the quiet count
  task t_hold;
    int n;
    for (int c = 0; c < 4; c++) begin
      cfg(1'b1, c[3:0], 3'h7);
      n = 256 << c;
      u_dac_sample_source.send(n - 2, 24'h64);
      u_dac_sample_source.send(1, 24'h4e20);
      u_dac_sample_source.send(n - 1, 24'h64);
      apb(1'b0, A_ST, 32'h0);
      check(rd[1:0], 2'h0);
      u_dac_sample_source.send(1, 24'h64);
      apb(1'b0, A_ST, 32'h0);
      check(rd[1:0], 2'h1);
      apb(1'b1, A_CTL, 32'h0);
      apb(1'b0, A_ST, 32'h0);
      check(rd[8:0], 9'h0);
    end
  endtask
  task t_gate(input logic dn, input logic up);
    int n;
    int su;
    n = 0;
    su = up ? 2 : 3;
    cfg(1'b1, {dn, up, 2'h0}, 3'h7);
    u_dac_sample_source.send(256, 24'h64);
    while (muted !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(n >= 48 * (dn + 1) && n <= 48 * (dn + 1) + 4, 1'b1);
    u_dac_sample_source.send(1, 24'h64);
    @(negedge clk);
    check(l_out, 24'h0);
    u_dac_sample_source.send(1, 24'h4e20);
    repeat (6 * su) @(posedge clk);
    apb(1'b0, A_ST, 32'h0);
    check(rd[1:0], 2'h3);
    repeat (6 * su) @(posedge clk);
    apb(1'b0, A_ST, 32'h0);
    check(rd[8:0], 9'h0);
  endtask
  // Every level code: just below engages, equal holds, one above releases
  task t_levels;
    logic [23:0] th;
    for (int c = 0; c < 8; c++) begin
      th = 24'h40 << c;
      cfg(1'b1, 4'h0, c[2:0]);
      u_dac_sample_source.send(256, th - 24'h1);
      repeat (60) @(negedge clk);
      check(muted, 1'b1);
      u_dac_sample_source.send(1, th);
      repeat (3) @(negedge clk);
      check(muted, 1'b1);
      u_dac_sample_source.send(1, th + 24'h1);
      repeat (3) @(negedge clk);
      check(muted, 1'b0);
    end
  endtask
  task t_enable;
    cfg(1'b0, 4'h0, 3'h7);
    u_dac_sample_source.send(300, 24'h64);
    @(negedge clk);
    check(muted, 1'b0);
    check(l_out, 24'h32);
    check(r_out, 24'hffff9c);
    check(vout, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_hold;
    t_gate(1'b0, 1'b0);
    t_gate(1'b1, 1'b1);
    t_levels;
    t_enable;
    conclude;
  end
  // Whole run needs about 22000 cycles; a hang is cut off well past that
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      conclude;
    end
  end
endmodule // dac_output_noise_gate_bench
`default_nettype wire
